// ===== logic/bsl_pkg.sv
// Strap capture constants and pin-state encodings.
// Assumes a single 200 MHz core clock domain.
package bsl_pkg;
  localparam int STRAP_COUNT = 9;
  // Pull default per strap, bit n is strap n (4..7 pull high)
  localparam logic [8:0] STRAP_DEFAULT = 9'h0f0;
  // Strap positions
  localparam int STRAP_SW1     = 1;
  localparam int STRAP_CLK_SEL = 4;
  localparam int STRAP_SW6     = 6;
  localparam int STRAP_SW7     = 7;
  localparam int STRAP_SW8     = 8;
  // Reference clock source
  localparam logic REF_SRC_CRYSTAL  = 1'b1;
  localparam logic REF_SRC_EXTERNAL = 1'b0;
  // Orientation
  localparam logic ORIENT_NORMAL  = 1'b0;
  localparam logic ORIENT_FLIPPED = 1'b1;
  // Pull encodings for pad control: 2'h1 up, 2'h2 down, 2'h0 none
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP   = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;
  typedef enum logic [1:0] {
    BSL_HELD    = 2'b00,
    BSL_CAPTURE = 2'b01,
    BSL_RUN     = 2'b10
  } bsl_state_e;
endpackage : bsl_pkg

// ===== logic/bsl_strap_latch.sv
// Strap latch: captures nine strap pins on power-on reset release.
// Assumes strap pins and por_input_n are asynchronous pins; CLK is the
// 200 MHz core clock, RESET the core asynchronous reset.
// Behaviour
// - Capture strap levels when reset rises.
// - Reset input active low, hold reset.
// - Strap four selects crystal or external clock.
// - Open straps take their pull level.
// - Straps 1,6,7,8 exposed to firmware.
// - Quad mode turns flash pins bidirectional.
// - Reset-time flash pin directions and pulls.
// - Drive reference clock on output pin.
// - Orientation pin low normal, high flipped.
// - Serial receive blocked in production.
// - Reference clock output enabled by strap.
`timescale 1ns/1ps
`default_nettype none
module bsl_strap_latch
  import bsl_pkg::*;
#(
  parameter int  NUM_STRAPS     = bsl_pkg::STRAP_COUNT,
  parameter bit  PRODUCTION     = 1'b1,
  parameter int  REFOUT_STRAP   = 0
) (
  input  wire logic                  CLK,                  // Core clock
  input  wire logic                  RESET,                // Async reset, high
  input  wire logic                  POR_INPUT_N,          // Power-on reset pin
  input  wire logic [NUM_STRAPS-1:0] STRAP_PINS,           // Strap pin levels
  input  wire logic                  REF_CLOCK_IN,         // Selected reference clock level
  input  wire logic                  QUAD_MODE,            // Quad flash mode request
  input  wire logic [3:0]            QUAD_OUT,             // Quad data to drive
  input  wire logic [3:0]            QUAD_OE,              // Quad lane drive enables
  input  wire logic                  FLASH_SELECT_N_FN,    // Functional chip select
  input  wire logic                  FLASH_CLOCK_FN,       // Functional flash clock
  input  wire logic                  FLASH_SERIAL_OUT_FN,  // Functional serial out
  input  wire logic                  ALERT_ORIENTATION_PIN,// Orientation pin level
  input  wire logic                  SERIAL_RX_PIN,        // Serial receive pin
  output logic                       CHIP_RESET,           // Chip held in reset
  output logic                       STRAPS_VALID,         // Straps captured
  output logic [NUM_STRAPS-1:0]      STRAP_VALUE,          // Captured straps
  output logic                       REF_SRC_SELECT,       // 1 crystal, 0 external
  output logic                       REF_CLOCK_OUT,        // Reference clock out
  output logic                       REF_CLOCK_OUT_OE,     // Ref clock drive enable
  output logic [3:0]                 APP_STRAPS,           // Straps 1,6,7,8
  output logic                       FLASH_SELECT_N,       // Chip select out
  output logic                       FLASH_SELECT_N_OE,    // Chip select enable
  output logic [1:0]                 FLASH_SELECT_N_PULL,  // Chip select pull
  output logic                       FLASH_CLOCK,          // Flash clock out
  output logic                       FLASH_CLOCK_OE,       // Flash clock enable
  output logic [1:0]                 FLASH_CLOCK_PULL,     // Flash clock pull
  output logic                       FLASH_SERIAL_IN_OE,   // Data-in drive enable
  output logic [1:0]                 FLASH_SERIAL_IN_PULL, // Data-in pull
  output logic [3:0]                 QUAD_IO_OUT,          // Quad lanes 0..3 out
  output logic [3:0]                 QUAD_IO_OE,           // Quad lanes 0..3 enable
  output logic [3:0]                 QUAD_IO_IN,           // Quad lane inputs, held low
  output logic                       ORIENTATION_FLIPPED,  // 1 flipped
  output logic                       SERIAL_RX_DATA        // Received serial level
);
  import bsl_pkg::*;

  // Logic serves exactly nine straps
  if (NUM_STRAPS != STRAP_COUNT) begin : g_bad_count
    $error("bsl_strap_latch: nine straps required");
  end
  if (REFOUT_STRAP < 0 || REFOUT_STRAP >= NUM_STRAPS) begin : g_bad_refout
    $error("bsl_strap_latch: bad REFOUT_STRAP");
  end

  typedef struct packed {
    bsl_state_e            state;
    logic [1:0]            por_sync;
    logic [NUM_STRAPS-1:0] strap_s1;
    logic [NUM_STRAPS-1:0] strap_s2;
    logic [1:0]            orient_sync;
    logic [1:0]            rx_sync;
    logic [1:0]            ref_sync;
    logic                  chip_reset;
    logic                  valid;
    logic [NUM_STRAPS-1:0] straps;
    logic                  ref_out;
    logic                  ref_oe;
    logic                  cs_n;
    logic                  cs_oe;
    logic [1:0]            cs_pull;
    logic                  fclk;
    logic                  fclk_oe;
    logic [1:0]            fclk_pull;
    logic                  di_oe;
    logic [1:0]            di_pull;
    logic [3:0]            q_out;
    logic [3:0]            q_oe;
    logic [3:0]            q_in;
    logic                  orient;
    logic                  rx;
  } bsl_state_s;

  bsl_state_s st;
  bsl_state_s next_st;

  localparam bsl_state_s RESET_ST = '{
    state: BSL_HELD, por_sync: 2'h0, strap_s1: STRAP_DEFAULT[NUM_STRAPS-1:0],
    strap_s2: STRAP_DEFAULT[NUM_STRAPS-1:0], orient_sync: 2'h0, rx_sync: 2'h3,
    ref_sync: 2'h0, chip_reset: 1'b1, valid: 1'b0,
    straps: STRAP_DEFAULT[NUM_STRAPS-1:0], ref_out: 1'b0, ref_oe: 1'b0,
    cs_n: 1'b1, cs_oe: 1'b1, cs_pull: PULL_UP, fclk: 1'b0, fclk_oe: 1'b1,
    fclk_pull: PULL_DOWN, di_oe: 1'b0, di_pull: PULL_DOWN, q_out: 4'h0,
    q_oe: 4'h0, q_in: 4'h0, orient: ORIENT_NORMAL, rx: 1'b1};

  always_comb begin
    next_st = st;
    next_st.por_sync    = {st.por_sync[0], POR_INPUT_N};
    next_st.strap_s1    = STRAP_PINS;
    next_st.strap_s2    = st.strap_s1;
    next_st.orient_sync = {st.orient_sync[0], ALERT_ORIENTATION_PIN};
    next_st.rx_sync     = {st.rx_sync[0], SERIAL_RX_PIN};
    next_st.ref_sync    = {st.ref_sync[0], REF_CLOCK_IN};
    unique case (st.state)
      BSL_HELD: begin
        next_st.chip_reset = 1'b1;
        next_st.valid      = 1'b0;
        if (st.por_sync[1]) begin
          next_st.state = BSL_CAPTURE;
        end
      end
      BSL_CAPTURE: begin
        next_st.straps = st.strap_s2;
        next_st.valid  = 1'b1;
        next_st.chip_reset = 1'b0;
        next_st.state  = BSL_RUN;
      end
      BSL_RUN: begin
        next_st.straps = st.straps;
        if (!st.por_sync[1]) begin
          next_st.state = BSL_HELD;
          next_st.chip_reset = 1'b1;
          next_st.valid = 1'b0;
        end
      end
      default: begin
        next_st.state = BSL_HELD;
      end
    endcase
    if (next_st.chip_reset) begin
      next_st.cs_n = 1'b1;
      next_st.cs_oe = 1'b1;
      next_st.cs_pull = PULL_UP;
      next_st.fclk = 1'b0;
      next_st.fclk_oe = 1'b1;
      next_st.fclk_pull = PULL_DOWN;
      next_st.di_oe = 1'b0;
      next_st.di_pull = PULL_DOWN;
      next_st.q_oe = 4'h0;
      next_st.q_out = 4'h0;
    end else begin
      next_st.cs_n = FLASH_SELECT_N_FN;
      next_st.cs_oe = 1'b1;
      next_st.cs_pull = PULL_NONE;
      next_st.fclk = FLASH_CLOCK_FN;
      next_st.fclk_oe = 1'b1;
      next_st.fclk_pull = PULL_NONE;
      next_st.di_pull = PULL_NONE;
      if (QUAD_MODE) begin
        next_st.q_out = QUAD_OUT;
        next_st.q_oe  = QUAD_OE;
        next_st.di_oe = QUAD_OE[1];
      end else begin
        next_st.q_out = {2'h3, 1'b0, FLASH_SERIAL_OUT_FN};
        next_st.q_oe  = 4'hd;
        next_st.di_oe = 1'b0;
      end
    end
    // Lane inputs not routed here; held low
    next_st.q_in = 4'h0;
    next_st.ref_oe  = st.valid & st.straps[REFOUT_STRAP];
    next_st.ref_out = next_st.ref_oe & st.ref_sync[1];
    next_st.orient = st.orient_sync[1] ? ORIENT_FLIPPED : ORIENT_NORMAL;
    next_st.rx = PRODUCTION ? 1'b1 : st.rx_sync[1];
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  assign CHIP_RESET           = st.chip_reset;
  assign STRAPS_VALID         = st.valid;
  assign STRAP_VALUE          = st.straps;
  assign REF_SRC_SELECT       = st.straps[STRAP_CLK_SEL];
  assign REF_CLOCK_OUT        = st.ref_out;
  assign REF_CLOCK_OUT_OE     = st.ref_oe;
  assign APP_STRAPS           = {st.straps[STRAP_SW8], st.straps[STRAP_SW7], st.straps[STRAP_SW6], st.straps[STRAP_SW1]};
  assign FLASH_SELECT_N       = st.cs_n;
  assign FLASH_SELECT_N_OE    = st.cs_oe;
  assign FLASH_SELECT_N_PULL  = st.cs_pull;
  assign FLASH_CLOCK          = st.fclk;
  assign FLASH_CLOCK_OE       = st.fclk_oe;
  assign FLASH_CLOCK_PULL     = st.fclk_pull;
  assign FLASH_SERIAL_IN_OE   = st.di_oe;
  assign FLASH_SERIAL_IN_PULL = st.di_pull;
  assign QUAD_IO_OUT          = st.q_out;
  assign QUAD_IO_OE           = st.q_oe;
  assign QUAD_IO_IN           = st.q_in;
  assign ORIENTATION_FLIPPED  = st.orient;
  assign SERIAL_RX_DATA       = st.rx;
endmodule : bsl_strap_latch
`default_nettype wire

// ===== verif/bsl_strap_latch_asserts.sv
// Checker: strap capture and reset pad states at the latch ports.
// Assumes a bind onto bsl_strap_latch and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bsl_strap_latch_asserts
  import bsl_pkg::*;
#(parameter int REFOUT_STRAP = 0) (
  input wire logic       CLK,                  // Clock
  input wire logic       RESET,                // Reset
  input wire logic       POR_INPUT_N,          // Reset pin
  input wire logic       CHIP_RESET,           // In reset
  input wire logic       STRAPS_VALID,         // Captured
  input wire logic [8:0] STRAP_VALUE,          // Straps
  input wire logic       REF_SRC_SELECT,       // Clock source
  input wire logic       REF_CLOCK_OUT_OE,     // Ref enable
  input wire logic [3:0] APP_STRAPS,           // App straps
  input wire logic       FLASH_SELECT_N_OE,    // Select enable
  input wire logic [1:0] FLASH_SELECT_N_PULL,  // Select pull
  input wire logic       FLASH_CLOCK_OE,       // Clock enable
  input wire logic [1:0] FLASH_CLOCK_PULL,     // Clock pull
  input wire logic       FLASH_SERIAL_IN_OE,   // Data-in enable
  input wire logic [1:0] FLASH_SERIAL_IN_PULL, // Data-in pull
  input wire logic       SERIAL_RX_DATA        // Rx level
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  AST_CAPT: assert property ($rose(STRAPS_VALID) |-> !CHIP_RESET && $past(POR_INPUT_N, 3))
    else $error("capture without release");
  AST_PORLOW: assert property (!POR_INPUT_N [*5] |-> CHIP_RESET)
    else $error("reset pin ignored");
  AST_CFG: assert property (STRAPS_VALID && $past(STRAPS_VALID) |-> REF_SRC_SELECT == STRAP_VALUE[4]
    && APP_STRAPS == {STRAP_VALUE[8:6], STRAP_VALUE[1]}) else $error("config fields wrong");
  AST_HOLD: assert property (STRAPS_VALID && $past(STRAPS_VALID) |-> $stable(STRAP_VALUE))
    else $error("straps changed");
  AST_REFOE: assert property ($past(STRAPS_VALID, 2) && STRAPS_VALID |->
    REF_CLOCK_OUT_OE == STRAP_VALUE[REFOUT_STRAP]) else $error("ref enable wrong");
  AST_PADS: assert property (CHIP_RESET && $past(CHIP_RESET) |-> FLASH_SELECT_N_OE && FLASH_CLOCK_OE
    && FLASH_SELECT_N_PULL == PULL_UP && FLASH_CLOCK_PULL == PULL_DOWN) else $error("pad reset state wrong");
  AST_DI: assert property (CHIP_RESET |-> !FLASH_SERIAL_IN_OE && FLASH_SERIAL_IN_PULL == PULL_DOWN)
    else $error("data-in not input");
  AST_RX: assert property (SERIAL_RX_DATA)
    else $error("serial receive not blocked");
endmodule : bsl_strap_latch_asserts
bind bsl_strap_latch bsl_strap_latch_asserts #(.REFOUT_STRAP(REFOUT_STRAP)) bsl_strap_latch_asserts_inst (.CLK,
  .RESET, .POR_INPUT_N, .CHIP_RESET, .STRAPS_VALID, .STRAP_VALUE, .REF_SRC_SELECT, .REF_CLOCK_OUT_OE, .APP_STRAPS,
  .FLASH_SELECT_N_OE, .FLASH_SELECT_N_PULL, .FLASH_CLOCK_OE, .FLASH_CLOCK_PULL, .FLASH_SERIAL_IN_OE,
  .FLASH_SERIAL_IN_PULL, .SERIAL_RX_DATA);
`default_nettype wire

// ===== verif/bsl_board.sv
// Board model: strap resistors and reset source.
// Assumes the bench picks fitted straps and reset timing.
`timescale 1ns/1ps
`default_nettype none
module bsl_board (
  input  wire logic       hold,  // Reset held
  input  wire logic [8:0] en,    // Resistor fitted
  input  wire logic [8:0] val,   // Fitted level
  output logic            por_n, // Reset pin
  output logic [8:0]      pins   // Strap pins
);
  import bsl_pkg::*;
  wire logic [8:0] fit = en & ~9'h02d;
  assign por_n = ~hold;
  assign pins = (fit & val) | (~fit & STRAP_DEFAULT);
endmodule : bsl_board
`default_nettype wire

// ===== verif/tb.sv
// Testbench: strap capture, reset pin, lane and pin mapping.
// Assumes a 200 MHz clock and the board model for straps and reset.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bsl_pkg::*;
  logic       clk = 0, reset = 1, hold = 1, quad = 0, ref_in = 0, orient = 0, rx = 1;
  logic       por_n, chip_rst, valid, src, ref_out, ref_oe, flip, rx_data;
  logic       cs_fn = 0, clk_fn = 1, so_fn = 1, cs_n, cs_oe, fclk, fclk_oe, di_oe;
  logic [1:0] cs_pull, fclk_pull, di_pull;
  logic [8:0] en = 0, val = 0, pins, value;
  logic [3:0] q_out = 0, q_oe = 0, io_out, io_oe, io_in, app;
  int         mismatches = 0, comparisons = 0, cycles = 0;
  always #2.5 clk = ~clk;
  bsl_board bsl_board_inst (.hold(hold), .en(en), .val(val), .por_n(por_n), .pins(pins));
  bsl_strap_latch #(.REFOUT_STRAP(1)) bsl_strap_latch_inst (.CLK(clk), .RESET(reset), .POR_INPUT_N(por_n),
    .STRAP_PINS(pins), .REF_CLOCK_IN(ref_in), .QUAD_MODE(quad), .QUAD_OUT(q_out), .QUAD_OE(q_oe),
    .FLASH_SELECT_N_FN(cs_fn), .FLASH_CLOCK_FN(clk_fn), .FLASH_SERIAL_OUT_FN(so_fn), .ALERT_ORIENTATION_PIN(orient),
    .SERIAL_RX_PIN(rx), .CHIP_RESET(chip_rst), .STRAPS_VALID(valid), .STRAP_VALUE(value), .REF_SRC_SELECT(src),
    .REF_CLOCK_OUT(ref_out), .REF_CLOCK_OUT_OE(ref_oe), .APP_STRAPS(app), .FLASH_SELECT_N(cs_n),
    .FLASH_SELECT_N_OE(cs_oe), .FLASH_SELECT_N_PULL(cs_pull), .FLASH_CLOCK(fclk), .FLASH_CLOCK_OE(fclk_oe),
    .FLASH_CLOCK_PULL(fclk_pull), .FLASH_SERIAL_IN_OE(di_oe), .FLASH_SERIAL_IN_PULL(di_pull),
    .QUAD_IO_OUT(io_out), .QUAD_IO_OE(io_oe), .QUAD_IO_IN(io_in), .ORIENTATION_FLIPPED(flip),
    .SERIAL_RX_DATA(rx_data));
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Board straps fitted, reset pulsed, wait for capture
  task automatic capture(input logic [8:0] e, input logic [8:0] v);
    @(negedge clk);
    en = e;
    val = v;
    hold = 1;
    repeat (6) @(negedge clk);
    check(chip_rst, 9'h001);
    check({cs_n, cs_oe, cs_pull}, {1'h1, 1'h1, PULL_UP});
    check({fclk, fclk_oe, fclk_pull, di_oe, di_pull}, {1'h0, 1'h1, PULL_DOWN, 1'h0, PULL_DOWN});
    hold = 0;
    for (int i = 0; i < 10 && valid !== 1'h1; i++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : capture
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      mismatches++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    check(value, 9'h0f0);
    check(rx_data, 9'h001);
    reset = 0;
    repeat (4) @(negedge clk);
    check(valid, 9'h000);
    capture(9'h000, 9'h000);
    check(value, 9'h0f0);
    check(src, 9'h001);
    check(app, 9'h006);
    check(ref_oe, 9'h000);
    check({cs_n, cs_oe, cs_pull}, {1'h0, 1'h1, PULL_NONE});
    check({fclk, fclk_oe, fclk_pull, di_oe, di_pull}, {1'h1, 1'h1, PULL_NONE, 1'h0, PULL_NONE});
    check({io_oe, io_out}, 9'h0dd);
    check(io_in, 9'h000);
    $display("open straps done");
    capture(9'h1d2, 9'h102);
    check(value, 9'h122);
    check(src, 9'h000);
    check(app, 9'h009);
    check(ref_oe, 9'h001);
    ref_in = 1;
    val = 9'h0d0;
    repeat (5) @(negedge clk);
    check(ref_out, 9'h001);
    check(value, 9'h122);
    $display("fitted straps done");
    quad = 1;
    q_out = 4'ha;
    q_oe = 4'h6;
    orient = 1;
    rx = 0;
    repeat (5) @(negedge clk);
    check(io_out, 9'h00a);
    check(io_oe, 9'h006);
    check(di_oe, 9'h001);
    check(flip, 9'h001);
    check(rx_data, 9'h001);
    orient = 0;
    repeat (5) @(negedge clk);
    check(flip, 9'h000);
    $display("pins done");
    end_of_test;
  end
endmodule : tb
`default_nettype wire
